/* src/link_mode_config_registers.sv */
// Station configuration, option, mode and reject-cause registers.
// Assumes the command interpreter and protocol engine give one-cycle events.
//
// Overview of operation
// - Config byte loads only on set-config command
// - Config CRC bit picks 16 or 32-bit
// - Config control bit picks modulo 8/128
// - Options load from table word 0; cleared
// - Option bit 8 selects X.75 procedure
// - X.75 adds three further reject triggers
// - Option bit 0 accepts flawed frames
// - Mode change mirrors when new-mode flag clear
// - Tx-table load sets tx enable silently
// - All acked clears tx enable, flags
// - Awaiting UA set mirrors and interrupts
// - Awaiting UA clear raises no interrupt
// - Mode byte holds seven link flags
// - Reset, connect, load, ack combinations
// - Recovery exit sets tx enable by acks
// - Disconnect clears link-up only
// - Cause fills on reject, clears leaving
// - Cause bit 7 is command/response
// - Cause bits 3,2 for N(R), length
// - Cause bits 0,1 control and info
// - Dump commands write mode and cause
// - Reset clears mode and cause registers
// - Mode change sets new-mode status flag
`timescale 1ns/1ns
`default_nettype none
module link_mode_config_registers
    import link_mode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic soft_reset,           // Software reset pulse
    input wire logic transparent_mode,     // Transparent operation level
    input wire logic monitor_test,         // Monitor test level
    input wire logic cmd_set_config,       // Set station configuration
    input wire logic [7:0] config_data,
    input wire logic cmd_load_options,     // Load option bits or station params
    input wire logic [15:0] table_word0,
    input wire logic cmd_load_tx_table,    // Load transmit table pointer done
    input wire logic cmd_start_link,       // Start link executed
    input wire logic ev_sabm_sent,         // SABM/SABME sent for reset
    input wire logic ev_connect,           // Entered S5 via SABM/UA
    input wire logic ev_all_acked,         // All sent I frames acked
    input wire logic ev_recovery_enter,    // Entered timer recovery
    input wire logic ev_recovery_exit,     // S7 to S5 on F=1
    input wire logic recovery_all_acked,   // Qualifies recovery exit
    input wire logic ev_disc,              // DISC received, S5 to S1
    input wire logic ev_retry_limit,       // Retry limit exceeded
    input wire logic ev_frmr_exit,         // Leaving frame reject mode
    input wire logic peer_busy_in,         // Remote busy level
    input wire logic ev_reject,            // Reject condition detected
    input wire reject_ev_t reject_in,
    input wire logic cmd_dump_regs,
    input wire logic cmd_dump_params,
    input wire logic mode_flag_clear,      // Host clears new-mode status
    output logic [7:0] station_config,
    output logic [15:0] link_options,
    output logic [7:0] link_mode_flags,
    output logic [7:0] reject_cause,
    output logic crc32_select,
    output logic modulo128_select,
    output logic accept_bad_frames,
    output logic x75_select,
    output logic mode_change_flag,
    output logic retry_limit_hit,
    output logic all_info_acked,
    output logic mode_irq,                 // New-mode interrupt pulse
    output logic ack_irq,                  // All-acked interrupt pulse
    output mirror_t mirror,
    output logic mirror_valid,
    output logic [7:0] mirror_word
);

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] config_q, config_d;
    logic [15:0] opt_q, opt_d;
    logic [7:0] mode_q, mode_d;
    logic [7:0] cause_q, cause_d;
    logic new_mode_q, new_mode_d;
    logic rtry_q, rtry_d;
    logic all_acked_q, all_acked_d;
    logic mirror_valid_q, mirror_valid_d;
    mirror_t mirror_q, mirror_d;
    logic mode_irq_q, mode_irq_d;
    logic ack_irq_q, ack_irq_d;

    // Software reset pulse only; hardware reset acts in the flops
    wire soft_clr = soft_reset;

    // ************************************************************
    // Option decode
    // ************************************************************
    // CRC width select
    assign crc32_select = config_q[CFG_CRC32_BIT];
    assign modulo128_select = config_q[CFG_MOD128_BIT];
    assign x75_select = opt_q[OPT_X75_BIT] & ~transparent_mode;
    assign accept_bad_frames = opt_q[OPT_BADOK_BIT] & ~transparent_mode;

    // Extra reject triggers only under X.75
    wire x75_trigger = x75_select &
        (reject_in.f_unsolicited | reject_in.unexpected_ua | reject_in.bad_ns);
    // X.25 base triggers always apply, too-long only outside monitor test
    wire base_trigger = reject_in.bad_nr | reject_in.bad_ctrl | reject_in.bad_info |
        (reject_in.too_long & ~monitor_test);
    wire reject_take = ev_reject & ~transparent_mode & (base_trigger | x75_trigger);

    // Type bit; N(R) and length bits; control bits
    wire [7:0] cause_new = {reject_in.is_response, 3'h0, reject_in.bad_nr,
        reject_in.too_long & ~monitor_test, reject_in.bad_info,
        reject_in.bad_ctrl | reject_in.bad_info};

    // ************************************************************
    // Register next state
    // ************************************************************
    // Priority: reset first, then link events, then host commands, except that start link beats connect on awaiting UA
    always_comb
    begin
        config_d = config_q;
        opt_d = opt_q;
        mode_d = mode_q;
        cause_d = cause_q;
        rtry_d = rtry_q | ev_retry_limit;
        all_acked_d = all_acked_q;
        ack_irq_d = 1'b0;
        if (cmd_set_config)
        begin
            config_d = (config_data & 8'h0a) | CFG_FIXED;
        end
        // Option load, reserved bits kept zero
        if (cmd_load_options)
        begin
            opt_d = table_word0 & OPT_MASK;
        end
        // Extended control mirrors into the mode byte
        mode_d[MODE_MOD128] = config_d[CFG_MOD128_BIT];
        mode_d[MODE_PEER_BUSY] = peer_busy_in & ~transparent_mode;
        if (cmd_load_tx_table)
        begin
            mode_d[MODE_TX_EN] = 1'b1;
            all_acked_d = 1'b0;
        end
        if (ev_connect)
        begin
            mode_d[MODE_TX_EN] = 1'b0;
            mode_d[MODE_LINK_UP] = 1'b1;
            mode_d[MODE_AWAIT_UA] = 1'b0;
            all_acked_d = 1'b0;
        end
        if (ev_all_acked)
        begin
            mode_d[MODE_TX_EN] = 1'b0;
            all_acked_d = 1'b1;
            ack_irq_d = 1'b1;
        end
        if (ev_recovery_enter)
        begin
            mode_d[MODE_TMR_RECOVERY] = 1'b1;
        end
        if (ev_recovery_exit)
        begin
            mode_d[MODE_TMR_RECOVERY] = 1'b0;
            mode_d[MODE_TX_EN] = ~recovery_all_acked;
            all_acked_d = recovery_all_acked;
        end
        // Disconnect leaves tx enable and acks alone
        if (ev_disc)
        begin
            mode_d[MODE_LINK_UP] = 1'b0;
        end
        if (cmd_start_link | ev_sabm_sent)
        begin
            mode_d[MODE_AWAIT_UA] = 1'b1;
        end
        // Retry limit ends the wait without its own interrupt
        if (ev_retry_limit)
        begin
            mode_d[MODE_AWAIT_UA] = 1'b0;
        end
        if (reject_take)
        begin
            mode_d[MODE_FRMR] = 1'b1;
            cause_d = cause_new;
        end
        else if (ev_frmr_exit)
        begin
            mode_d[MODE_FRMR] = 1'b0;
            cause_d = RESET_BYTE;
        end
        if (soft_clr)
        begin
            config_d = RESET_BYTE;
            opt_d = RESET_WORD;
            mode_d = RESET_BYTE;
            cause_d = RESET_BYTE;
            rtry_d = 1'b0;
            all_acked_d = 1'b0;
            ack_irq_d = 1'b0;
        end
    end

    // Tx enable alone is not a reportable change
    wire [7:0] report_mask = 8'h7f;
    // Awaiting UA falling alone is not reported
    wire await_fall = mode_q[MODE_AWAIT_UA] & ~mode_d[MODE_AWAIT_UA];
    wire [7:0] diff = (mode_d ^ mode_q) & report_mask &
        ~({3'h0, await_fall, 4'h0});
    wire reportable = (|diff) | (cause_d != cause_q);

    // Mirror writes and the new-mode flag, kept apart from the next state
    // above so that no combinational loop runs through the change test
    always_comb
    begin
        new_mode_d = new_mode_q;
        mirror_d = mirror_q;
        mirror_valid_d = 1'b0;
        mode_irq_d = 1'b0;
        // Host clear of the new-mode status
        if (mode_flag_clear)
        begin
            new_mode_d = 1'b0;
        end
        // Mirror only on reportable change with flag clear
        // A clear in the same cycle frees the flag, so the set wins
        if (reportable && (!new_mode_q || mode_flag_clear))
        begin
            new_mode_d = 1'b1;
            mirror_valid_d = 1'b1;
            mode_irq_d = 1'b1;
            mirror_d = '{dst: DST_TABLE, mode: mode_d, cause: cause_d};
        end
        else if (cmd_dump_params | cmd_dump_regs)
        begin
            mirror_valid_d = 1'b1;
            mirror_d = '{dst: cmd_dump_params ? DST_TABLE : DST_DUMP, mode: mode_d, cause: cause_d};
        end
        // Software reset drops the flag and pending writes
        if (soft_clr)
        begin
            new_mode_d = 1'b0;
            mirror_valid_d = 1'b0;
            mode_irq_d = 1'b0;
        end
    end

    // ************************************************************
    // Flops
    // ************************************************************
    // Hardware reset clears all
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            config_q <= RESET_BYTE;
            opt_q <= RESET_WORD;
            mode_q <= RESET_BYTE;
            cause_q <= RESET_BYTE;
            new_mode_q <= 1'b0;
            rtry_q <= 1'b0;
            all_acked_q <= 1'b0;
            mirror_valid_q <= 1'b0;
            mirror_q <= '{dst: DST_NONE, mode: 8'h00, cause: 8'h00};
            mode_irq_q <= 1'b0;
            ack_irq_q <= 1'b0;
        end
        else
        begin
            config_q <= config_d;
            opt_q <= opt_d;
            mode_q <= mode_d;
            cause_q <= cause_d;
            new_mode_q <= new_mode_d;
            rtry_q <= rtry_d;
            all_acked_q <= all_acked_d;
            mirror_valid_q <= mirror_valid_d;
            mirror_q <= mirror_d;
            mode_irq_q <= mode_irq_d;
            ack_irq_q <= ack_irq_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign station_config = config_q;
    assign link_options = opt_q;
    assign link_mode_flags = mode_q;
    assign reject_cause = cause_q;
    assign mode_change_flag = new_mode_q;
    assign retry_limit_hit = rtry_q;
    assign all_info_acked = all_acked_q;
    assign mode_irq = mode_irq_q;
    assign ack_irq = ack_irq_q;
    assign mirror = mirror_q;
    assign mirror_valid = mirror_valid_q;
    // Mode byte goes to high byte of word 21
    assign mirror_word = TBL_MODE_WORD;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_CFG_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        !cmd_set_config && !soft_reset |=> $stable(station_config))
        else $error("config changed without command");
    AST_OPT_RES: assert property (@(posedge clock) disable iff (!resetn)
        cmd_load_options && !soft_reset |=> link_options == ($past(table_word0) & OPT_MASK))
        else $error("option load wrong");
    AST_X75: assert property (@(posedge clock) disable iff (!resetn)
        x75_select |-> link_options[8] && !transparent_mode)
        else $error("x75 select wrong");
    AST_TXEN: assert property (@(posedge clock) disable iff (!resetn)
        cmd_load_tx_table && !ev_connect && !ev_all_acked && !ev_recovery_exit && !soft_reset
        |=> link_mode_flags[MODE_TX_EN])
        else $error("tx enable not set");
    AST_ACK: assert property (@(posedge clock) disable iff (!resetn)
        ev_all_acked && !ev_recovery_exit && !soft_reset |=> all_info_acked && ack_irq)
        else $error("ack flag missing");
    AST_MIRROR: assert property (@(posedge clock) disable iff (!resetn)
        mode_irq |-> mirror_valid && mirror.dst == DST_TABLE &&
        (!$past(mode_change_flag) || $past(mode_flag_clear)))
        else $error("mirror while flag set");
    AST_DISC: assert property (@(posedge clock) disable iff (!resetn)
        ev_disc && !soft_reset && !cmd_load_tx_table && !ev_all_acked && !ev_recovery_exit
        && !ev_connect |=> !link_mode_flags[MODE_LINK_UP] && $stable(all_info_acked))
        else $error("disconnect effect wrong");
    AST_CAUSE: assert property (@(posedge clock) disable iff (!resetn)
        reject_cause[RC_BAD_INFO] |-> reject_cause[RC_BAD_CTRL])
        else $error("info bit without control bit");
    AST_SOFT: assert property (@(posedge clock) disable iff (!resetn)
        soft_reset |=> link_mode_flags == 8'h00 && reject_cause == 8'h00)
        else $error("soft reset did not clear");

endmodule : link_mode_config_registers
`default_nettype wire

/* src/link_mode_pkg.sv */
// Package for the link mode configuration register bank.
// Assumes a single 125 MHz clock domain and an external protocol engine.
package link_mode_pkg;

    // ************************************************************
    // Register layouts and bit positions
    // ************************************************************
    localparam int CFG_CRC32_BIT = 3;         // Extended CRC select
    localparam int CFG_MOD128_BIT = 1;        // Extended control select
    localparam logic [7:0] CFG_FIXED = 8'ha0; // Fixed ones in config byte
    localparam int OPT_X75_BIT = 8;          // Link procedure select
    localparam int OPT_BADOK_BIT = 0;        // Accept flawed frames
    localparam logic [15:0] OPT_MASK = 16'h0101; // Implemented option bits
    // Mode byte positions
    localparam int MODE_TX_EN = 7;
    localparam int MODE_MOD128 = 6;
    localparam int MODE_LINK_UP = 5;
    localparam int MODE_AWAIT_UA = 4;
    localparam int MODE_FRMR = 3;
    localparam int MODE_TMR_RECOVERY = 2;
    localparam int MODE_PEER_BUSY = 1;
    // Reject cause positions
    localparam int RC_RESP = 7;
    localparam int RC_BAD_NR = 3;
    localparam int RC_TOO_LONG = 2;
    localparam int RC_BAD_INFO = 1;
    localparam int RC_BAD_CTRL = 0;
    // Station table word holding the mode byte
    localparam logic [7:0] TBL_MODE_WORD = 8'h15;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Destination of a mirror write
    typedef enum logic [1:0] {DST_NONE, DST_TABLE, DST_DUMP} mirror_dst_t;

    // Reject events from the protocol engine
    typedef struct packed {
        logic is_response;    // Offending frame was a response
        logic bad_nr;         // Invalid N(R)
        logic too_long;       // Info field longer than buffer
        logic bad_info;       // Info field not allowed
        logic bad_ctrl;       // Invalid control field
        logic f_unsolicited;  // S frame F=1 not expected
        logic unexpected_ua;  // Unexpected UA or DM
        logic bad_ns;         // Invalid N(S)
    } reject_ev_t;

    // Mirror write to host memory
    typedef struct packed {
        mirror_dst_t dst;
        logic [7:0] mode;
        logic [7:0] cause;
    } mirror_t;

endpackage : link_mode_pkg

/* tb/host_table_model.sv */
// Host memory model: station table mode and cause bytes plus the dump area.
// Assumes mirror writes arrive as one-cycle pulses on the design clock.
`timescale 1ns/1ns
`default_nettype none
module host_table_model
    import link_mode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire mirror_t mirror,      // Write destination and bytes
    input wire logic mirror_valid,   // One-cycle write strobe
    input wire logic [7:0] mirror_word, // Table word of the mode byte
    output logic [7:0] tbl_mode,     // Table copy of the mode byte
    output logic [7:0] tbl_cause,    // Table copy of the cause byte
    output logic [7:0] dump_mode,    // Dump area mode byte
    output logic [7:0] dump_cause    // Dump area cause byte
);
    // ********************
    // Memory writes
    // ********************
    // Memory only changes on a strobe, so a missing write leaves stale bytes
    // table and dump
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            tbl_mode <= RESET_BYTE;
            tbl_cause <= RESET_BYTE;
            dump_mode <= RESET_BYTE;
            dump_cause <= RESET_BYTE;
        end
        else if (mirror_valid && mirror.dst == DST_TABLE && mirror_word == 8'h15)
        begin
            // Word 21 high byte and cause slot
            tbl_mode <= mirror.mode;
            tbl_cause <= mirror.cause;
        end
        else if (mirror_valid && mirror.dst == DST_DUMP)
        begin
            // Dump area slots
            dump_mode <= mirror.mode;
            dump_cause <= mirror.cause;
        end
    end
endmodule : host_table_model
`default_nettype wire

/* tb/test_link_mode_config_registers.sv */
// Self-checking bench for the link mode register bank.
// Assumes one-cycle registered answers to one-cycle command pulses.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module test_link_mode_config_registers
    import link_mode_pkg::*;
;
    // ********************
    // Stimulus and outputs
    // ********************
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [16:0] ev = '0; // One-hot command pulses
    logic transparent_mode = 1'b0, monitor_test = 1'b0, peer_busy_in = 1'b0;
    logic [7:0] config_data = 8'h00, d_cfg = 8'h00, v, keep;
    logic [15:0] table_word0 = 16'h0000, d_opt = 16'h0000;
    reject_ev_t reject_in = '0, d_rej = '0;
    logic recovery_all_acked = 1'b0, d_rall = 1'b0;
    logic [7:0] station_config, link_mode_flags, reject_cause, mirror_word;
    logic [15:0] link_options;
    logic crc32_select, modulo128_select, accept_bad_frames, x75_select, mode_change_flag;
    logic retry_limit_hit, all_info_acked, mode_irq, ack_irq, mirror_valid;
    mirror_t mirror;
    logic [7:0] tbl_mode, tbl_cause, dump_mode, dump_cause;
    int failures = 0, n_checks = 0;
    // Free-running 125 MHz clock
    always #4 clock = ~clock;
    link_mode_config_registers uut (.clock(clock), .resetn(resetn), .soft_reset(ev[0]),
        .transparent_mode(transparent_mode), .monitor_test(monitor_test), .cmd_set_config(ev[1]),
        .config_data(config_data), .cmd_load_options(ev[2]), .table_word0(table_word0),
        .cmd_load_tx_table(ev[3]), .cmd_start_link(ev[4]), .ev_sabm_sent(ev[5]), .ev_connect(ev[6]),
        .ev_all_acked(ev[7]), .ev_recovery_enter(ev[8]), .ev_recovery_exit(ev[9]),
        .recovery_all_acked(recovery_all_acked), .ev_disc(ev[10]), .ev_retry_limit(ev[11]),
        .ev_frmr_exit(ev[12]), .peer_busy_in(peer_busy_in), .ev_reject(ev[13]), .reject_in(reject_in),
        .cmd_dump_regs(ev[14]), .cmd_dump_params(ev[15]), .mode_flag_clear(ev[16]),
        .station_config(station_config), .link_options(link_options), .link_mode_flags(link_mode_flags),
        .reject_cause(reject_cause), .crc32_select(crc32_select), .modulo128_select(modulo128_select),
        .accept_bad_frames(accept_bad_frames), .x75_select(x75_select), .mode_change_flag(mode_change_flag),
        .retry_limit_hit(retry_limit_hit), .all_info_acked(all_info_acked), .mode_irq(mode_irq),
        .ack_irq(ack_irq), .mirror(mirror), .mirror_valid(mirror_valid), .mirror_word(mirror_word));
    host_table_model partner (.clock(clock), .resetn(resetn), .mirror(mirror), .mirror_valid(mirror_valid),
        .mirror_word(mirror_word), .tbl_mode(tbl_mode), .tbl_cause(tbl_cause), .dump_mode(dump_mode),
        .dump_cause(dump_cause));
    // ********************
    // Helpers
    // ********************
    // Expected cause byte; the info fault drags the control fault along
    function automatic logic [7:0] exp_cause(input reject_ev_t e, input logic mon);
        return {e.is_response, 3'b000, e.bad_nr, e.too_long & ~mon, e.bad_info, e.bad_ctrl | e.bad_info};
    endfunction : exp_cause
    // One pulse with staged data; returns where the answer has settled
    task automatic fire(input int i);
        @(posedge clock);
        ev <= 17'h1 << i;
        config_data <= d_cfg;
        table_word0 <= d_opt;
        reject_in <= d_rej;
        recovery_all_acked <= d_rall;
        @(posedge clock);
        ev <= '0;
        @(negedge clock);
    endtask : fire
    // Level inputs change on a rising edge
    task automatic lvl(input logic t, input logic m, input logic p);
        @(posedge clock);
        transparent_mode <= t;
        monitor_test <= m;
        peer_busy_in <= p;
        @(negedge clock);
    endtask : lvl
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Hang guard
    initial
    begin
        #400000;
        failures++;
        print_verdict();
    end
    // ********************
    // Main sequence
    // ********************
    initial
    begin
        void'($urandom(32'h08ccf64a));
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        `CHK({station_config, link_options, link_mode_flags, reject_cause}, 40'h0)
        `CHK({mode_change_flag, all_info_acked, retry_limit_hit}, 3'b000)
        // Config loads on its command only
        for (int k = 0; k < 4; k++)
        begin
            d_cfg = (k == 0) ? 8'hff : 8'($urandom);
            fire(1);
            `CHK(station_config, CFG_FIXED | (d_cfg & 8'h0a))
            `CHK({crc32_select, modulo128_select}, {d_cfg[3], d_cfg[1]})
            keep = station_config;
            d_cfg = ~d_cfg;
            fire(14);
            `CHK(station_config, keep)
        end
        // Options, with and without transparent operation
        for (int k = 0; k < 4; k++)
        begin
            d_opt = (k == 0) ? 16'hffff : 16'($urandom);
            lvl(k[1], 1'b0, 1'b0);
            fire(2);
            `CHK(link_options, d_opt & 16'h0101)
            `CHK({x75_select, accept_bad_frames}, {d_opt[8], d_opt[0]} & {2{~k[1]}})
        end
        lvl(1'b0, 1'b0, 1'b0);
        // Start link and link reset, then retry exhaustion
        for (int k = 0; k < 2; k++)
        begin
            fire(16);
            fire(k ? 5 : 4);
            `CHK({link_mode_flags[MODE_AWAIT_UA], mode_change_flag, mode_irq, mirror_valid}, 4'hf)
            `CHK({mirror.dst, mirror_word, mirror.mode[MODE_AWAIT_UA]}, {DST_TABLE, 8'h15, 1'b1})
            fire(11);
            `CHK({retry_limit_hit, link_mode_flags[MODE_AWAIT_UA], mode_irq}, 3'b100)
        end
        fire(16);
        fire(6);
        `CHK({link_mode_flags[MODE_TX_EN], link_mode_flags[MODE_LINK_UP], all_info_acked, mode_irq}, 4'b0101)
        fire(16);
        fire(3);
        `CHK({link_mode_flags[MODE_TX_EN], mode_change_flag, mirror_valid}, 3'b100)
        fire(7);
        `CHK({link_mode_flags[7], link_mode_flags[5], all_info_acked, ack_irq, mirror_valid}, 5'b01110)
        // Recovery exit, all acked then some pending
        for (int k = 0; k < 2; k++)
        begin
            d_rall = (k == 0);
            fire(3);
            fire(8);
            `CHK(link_mode_flags[MODE_TMR_RECOVERY], 1'b1)
            fire(9);
            `CHK({link_mode_flags[MODE_TX_EN], all_info_acked, link_mode_flags[2]}, {~d_rall, d_rall, 1'b0})
        end
        fire(10);
        `CHK({link_mode_flags[MODE_TX_EN], link_mode_flags[MODE_LINK_UP], all_info_acked}, 3'b100)
        // Flag held: silent update, then the host fetches by dump
        `CHK(mode_change_flag, 1'b1)
        fire(8);
        `CHK(mirror_valid, 1'b0)
        fire(15);
        `CHK({mirror_valid, mirror.dst, mirror.mode}, {1'b1, DST_TABLE, link_mode_flags})
        fire(14);
        `CHK({tbl_mode, mirror.dst}, {link_mode_flags, DST_DUMP})
        lvl(1'b0, 1'b0, 1'b0);
        `CHK({dump_mode, dump_cause}, {link_mode_flags, reject_cause})
        // Random X.25 rejects; only the first one reaches the table
        fire(16);
        for (int k = 0; k < 6; k++)
        begin
            v = 8'($urandom) & 8'hf8;
            if ((v & 8'h58) == 8'h00)
                v = v | 8'h08;
            d_rej = v;
            lvl(1'b0, k[0], 1'b0);
            fire(13);
            `CHK({link_mode_flags[MODE_FRMR], reject_cause}, {1'b1, exp_cause(d_rej, k[0])})
            if (k == 0)
                keep = reject_cause;
            fire(12);
            `CHK({link_mode_flags[MODE_FRMR], reject_cause, tbl_cause}, {1'b0, 8'h00, keep})
        end
        // Extra reject triggers count only under X.75
        for (int k = 0; k < 6; k++)
        begin
            d_opt = {7'h00, k[0], 8'h00};
            d_rej = 8'h80 | (8'h01 << (k / 2));
            fire(2);
            fire(13);
            `CHK({link_mode_flags[MODE_FRMR], reject_cause[RC_RESP]}, {2{k[0]}})
            fire(12);
        end
        // Remote busy shows in the mode byte in normal operation
        lvl(1'b0, 1'b0, 1'b1);
        fire(16);
        `CHK(link_mode_flags[MODE_PEER_BUSY], 1'b1)
        // Transparent operation ignores rejects, options and the busy level
        lvl(1'b1, 1'b0, 1'b1);
        d_rej = 8'h08;
        fire(13);
        `CHK({reject_cause, x75_select, accept_bad_frames}, 10'h0)
        `CHK(link_mode_flags[MODE_PEER_BUSY], 1'b0)
        fire(0);
        `CHK({station_config, link_options, link_mode_flags, reject_cause, mode_change_flag}, 41'h0)
        print_verdict();
    end
endmodule : test_link_mode_config_registers
`default_nettype wire
